// >>> rtl/tblwr_exec.sv
`timescale 1ns/10ps
module tblwr_exec
  import tblwr_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // Instruction fetch
  input  wire logic                   instr_valid,
  input  wire logic [OPCODE_W-1:0]    instr_word,
  // Core state
  input  wire logic [DATA_W-1:0]      table_latch,
  input  wire logic                   ptr_load,
  input  wire logic [PTR_W-1:0]       ptr_load_value,
  input  wire logic [STATUS_W-1:0]    status_in,
  // Holding register read port
  input  wire logic [HOLD_AW-1:0]     hold_rd_addr,
  output logic      [DATA_W-1:0]      hold_rd_data,
  // Results
  output logic [PTR_W-1:0]            table_pointer,
  output logic [STATUS_W-1:0]         status_out,
  output logic                        busy,
  output logic                        done,
  output logic                        hold_wr_strobe,
  output logic [HOLD_AW-1:0]          hold_wr_index,
  output logic                        hold_wr_high_byte,
  output logic [1:0]                  phase
);
  import tblwr_pkg::*;

  tblwr_state_e      state_reg;
  logic [1:0]        mode_reg;
  logic [DATA_W-1:0] latch_reg;
  logic              wr_en;
  logic [HOLD_AW-1:0] wr_addr;

  // Quarter-cycle phase counter
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      phase <= PHASE_Q1;
    else
      phase <= phase + 2'h1;
  end

  // Sequencer, decode on Q1 of the first cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg <= TBLWR_IDLE;
      mode_reg  <= MODE_NONE;
    end
    else
    begin
      unique case (state_reg)
        TBLWR_IDLE:
          if (phase == PHASE_Q1 && instr_valid && is_table_write(instr_word)) // see [RULE_01]
          begin
            state_reg <= TBLWR_DECODE;
            mode_reg  <= instr_word[1:0]; // see [RULE_01]
          end
        TBLWR_DECODE:
          if (phase == PHASE_Q4)
            state_reg <= TBLWR_EXEC; // see [RULE_07]
        TBLWR_EXEC:
          if (phase == PHASE_Q4)
            state_reg <= TBLWR_IDLE;
        default:
          state_reg <= TBLWR_IDLE;
      endcase
    end
  end

  // Latch captured in Q2 of execute
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      latch_reg <= DATA_RESET;
    else if (state_reg == TBLWR_EXEC && phase == PHASE_Q2)
      latch_reg <= table_latch; // see [RULE_07]
  end

  // Pointer update
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      table_pointer <= PTR_RESET; // see [RULE_04]
    else if (ptr_load && state_reg == TBLWR_IDLE)
      table_pointer <= ptr_load_value;
    else if (state_reg == TBLWR_DECODE && phase == PHASE_Q4 && mode_reg == MODE_PRE_INC)
      table_pointer <= table_pointer + 21'h000001; // see [RULE_06]
    else if (state_reg == TBLWR_EXEC && phase == PHASE_Q4)
    begin
      if (mode_reg == MODE_POST_INC)
        table_pointer <= table_pointer + 21'h000001; // see [RULE_06]
      else if (mode_reg == MODE_POST_DEC)
        table_pointer <= table_pointer - 21'h000001; // see [RULE_06]
    end
  end

  // Holding register write in Q4
  assign wr_en   = state_reg == TBLWR_EXEC && phase == PHASE_Q4; // see [RULE_07]
  assign wr_addr = table_pointer[HOLD_AW-1:0]; // see [RULE_02]

  tblwr_hold_mem u_hold (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (latch_reg),
    .rd_addr (hold_rd_addr),
    .rd_data (hold_rd_data)
  );

  // Registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      busy              <= 1'b0;
      done              <= 1'b0;
      hold_wr_strobe    <= 1'b0;
      hold_wr_index     <= 3'h0;
      hold_wr_high_byte <= 1'b0;
    end
    else
    begin
      busy              <= state_reg != TBLWR_IDLE;
      done              <= wr_en;
      hold_wr_strobe    <= wr_en;
      hold_wr_index     <= wr_addr;
      hold_wr_high_byte <= table_pointer[0]; // see [RULE_05]
    end
  end

  // Flags pass through untouched
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      status_out <= 5'h00;
    else
      status_out <= status_in; // see [RULE_08]
  end
endmodule : tblwr_exec

// >>> rtl/tblwr_hold_mem.sv
`timescale 1ns/10ps
module tblwr_hold_mem
  import tblwr_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Write side
  input  wire logic                  wr_en,
  input  wire logic [HOLD_AW-1:0]    wr_addr,
  input  wire logic [DATA_W-1:0]     wr_data,
  // Read side
  input  wire logic [HOLD_AW-1:0]    rd_addr,
  output logic      [DATA_W-1:0]     rd_data
);
  logic [DATA_W-1:0] hold_reg [HOLD_DEPTH];

  // Staging storage for programming
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < HOLD_DEPTH; i++)
        hold_reg[i] <= HOLD_RESET;
    end
    else if (wr_en)
      hold_reg[wr_addr] <= wr_data; // see [RULE_03]
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rd_data <= HOLD_RESET;
    else
      rd_data <= hold_reg[rd_addr];
  end
endmodule : tblwr_hold_mem

// >>> rtl/tblwr_pkg.sv
// Overview of operation
// [RULE_01] Decode opcode 0x000C..0x000F; low two bits choose the pointer mode.
// [RULE_02] Pointer bits 2..0 choose one of eight holding registers for the latch byte.
// [RULE_03] Holding registers stage bytes later programmed into program memory.
// [RULE_04] Table pointer is 21 bits, byte addressing a two-megabyte range.
// [RULE_05] Pointer bit 0 picks low byte (0) or high byte (1) of a word.
// [RULE_06] Pre-increment adjusts before the write; post modes adjust after it.
// [RULE_07] One word, two cycles: decode, then latch read Q2, holding write Q4.
// [RULE_08] Arithmetic status flags are never altered by this instruction.
package tblwr_pkg;
  localparam int          OPCODE_W      = 16;
  localparam int          PTR_W         = 21;
  localparam int          DATA_W        = 8;
  localparam int          HOLD_DEPTH    = 8;
  localparam int          HOLD_AW       = 3;
  localparam int          STATUS_W      = 5;
  localparam logic [13:0] TBLWR_OP_HI   = 14'h0003;
  localparam logic [1:0]  MODE_NONE     = 2'h0;
  localparam logic [1:0]  MODE_POST_INC = 2'h1;
  localparam logic [1:0]  MODE_POST_DEC = 2'h2;
  localparam logic [1:0]  MODE_PRE_INC  = 2'h3;
  localparam logic [1:0]  PHASE_Q1      = 2'h0;
  localparam logic [1:0]  PHASE_Q2      = 2'h1;
  localparam logic [1:0]  PHASE_Q4      = 2'h3;
  localparam logic [20:0] PTR_RESET     = 21'h000000;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [7:0]  HOLD_RESET    = 8'hFF;

  typedef enum logic [1:0] {
    TBLWR_IDLE   = 2'b00,
    TBLWR_DECODE = 2'b01,
    TBLWR_EXEC   = 2'b10
  } tblwr_state_e;

  function automatic logic is_table_write(input logic [15:0] op);
    return op[15:2] == TBLWR_OP_HI;
  endfunction : is_table_write
endpackage : tblwr_pkg

// >>> tb/tblwr_exec_chk.sv
`timescale 1ns/10ps
module tblwr_exec_chk
  import tblwr_pkg::*;
(
  // Watched ports
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire logic                instr_valid,
  input wire logic [OPCODE_W-1:0] instr_word,
  input wire logic                ptr_load,
  input wire logic [STATUS_W-1:0] status_in,
  input wire logic [PTR_W-1:0]    table_pointer,
  input wire logic [STATUS_W-1:0] status_out,
  input wire logic                busy,
  input wire logic                done,
  input wire logic                hold_wr_strobe,
  input wire logic [HOLD_AW-1:0]  hold_wr_index,
  input wire logic                hold_wr_high_byte,
  input wire logic [1:0]          phase
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  wire       take = !busy && phase == PHASE_Q1 && instr_valid && instr_word[15:2] == TBLWR_OP_HI;
  wire [2:0] ptr_lo = table_pointer[2:0];
  AST_LATENCY: assert property (take |=> ##1 busy [*6] ##1 (busy && done) ##1 (!busy && !done)) else $error("bad latency");
  AST_STROBE: assert property (hold_wr_strobe |-> done ##1 !hold_wr_strobe) else $error("bad strobe");
  AST_DONE_PH: assert property (done |-> phase == PHASE_Q1) else $error("bad done phase");
  AST_INDEX: assert property (hold_wr_strobe |-> hold_wr_index == $past(ptr_lo)) else $error("bad index");
  AST_HIGH: assert property (hold_wr_strobe |-> hold_wr_high_byte == hold_wr_index[0]) else $error("bad byte");
  AST_STATUS: assert property (!$past(reset) |-> status_out == $past(status_in)) else $error("bad status");
  AST_PHASE: assert property (!$past(reset) |-> phase == $past(phase) + 2'h1) else $error("bad phase");
  AST_PTR: assert property (!busy && !ptr_load |=> $stable(table_pointer)) else $error("ptr moved");
  cover property (take && instr_word[1:0] == MODE_PRE_INC);
  cover property (done && hold_wr_high_byte);
  cover property (instr_valid && phase == PHASE_Q1 && !busy && !take);
endmodule : tblwr_exec_chk

// >>> tb/tblwr_exec_tb.sv
`timescale 1ns/10ps
module tblwr_exec_tb;
  import tblwr_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, ptr_load = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] table_latch = 8'h00, hold_rd_data, staged_byte;
  logic [20:0] ptr_load_value = 21'h000000, table_pointer;
  logic [4:0] status_in = 5'h00, status_out;
  logic [2:0] stage_sel = 3'h0, hold_rd_addr, hold_wr_index;
  logic busy, done, hold_wr_strobe, hold_wr_high_byte;
  logic [1:0] phase;
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  tblwr_exec i_dut (.ref_clk, .reset, .instr_valid, .instr_word, .table_latch, .ptr_load, .ptr_load_value,
    .status_in, .hold_rd_addr, .hold_rd_data, .table_pointer, .status_out, .busy, .done, .hold_wr_strobe,
    .hold_wr_index, .hold_wr_high_byte, .phase);
  tblwr_flash_model i_model (.ref_clk, .stage_sel, .hold_rd_addr, .hold_rd_data, .staged_byte);
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic issue(logic [15:0] op);
    while (phase !== PHASE_Q1) @(negedge ref_clk);
    instr_word = op;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask : issue
  task automatic t_write(logic [1:0] m, logic [20:0] p, logic [7:0] d);
    logic [20:0] q, e;
    q = (m == MODE_PRE_INC) ? p + 21'h1 : p;
    e = (m == MODE_POST_INC) ? q + 21'h1 : (m == MODE_POST_DEC) ? q - 21'h1 : q;
    ptr_load_value = p;
    ptr_load = 1'b1;
    table_latch = d;
    status_in = d[4:0];
    @(negedge ref_clk);
    ptr_load = 1'b0;
    issue({TBLWR_OP_HI, m});
    for (int k = 0; k < 12 && done !== 1'b1; k++) @(negedge ref_clk);
    check("done", 1'b1, done);
    check("index", q[2:0], hold_wr_index);
    check("high", q[0], hold_wr_high_byte);
    check("pointer", e, table_pointer);
    check("status", d[4:0], status_out);
    stage_sel = q[2:0];
    repeat (2) @(negedge ref_clk);
    check("holding", d, staged_byte);
    $display("write mode %0d ended", m);
  endtask : t_write
  task automatic t_refuse();
    issue(16'h0010);
    repeat (2) @(negedge ref_clk);
    check("refused busy", 1'b0, busy);
    repeat (8) @(negedge ref_clk);
    $display("refuse test ended");
  endtask : t_refuse
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    t_write(MODE_NONE, 21'h000005, 8'hA1);
    t_write(MODE_POST_INC, 21'h00A356, 8'h55);
    t_write(MODE_POST_DEC, 21'h000000, 8'h3C);
    t_write(MODE_PRE_INC, 21'h01389A, 8'h34);
    t_write(MODE_PRE_INC, 21'h1FFFFF, 8'h77);
    t_refuse();
    complete_run();
  end
endmodule : tblwr_exec_tb
bind tblwr_exec tblwr_exec_chk i_chk (.ref_clk, .reset, .instr_valid, .instr_word, .ptr_load, .status_in,
  .table_pointer, .status_out, .busy, .done, .hold_wr_strobe, .hold_wr_index, .hold_wr_high_byte, .phase);

// >>> tb/tblwr_flash_model.sv
`timescale 1ns/10ps
module tblwr_flash_model
  import tblwr_pkg::*;
(
  // Staging read
  input  wire logic               ref_clk,
  input  wire logic [HOLD_AW-1:0] stage_sel,
  output logic      [HOLD_AW-1:0] hold_rd_addr,
  input  wire logic [DATA_W-1:0]  hold_rd_data,
  output logic      [DATA_W-1:0]  staged_byte
);
  assign hold_rd_addr = stage_sel;
  always_ff @(posedge ref_clk)
  begin
    staged_byte <= hold_rd_data;
  end
endmodule : tblwr_flash_model
